// file: hdl/pegq_port_egress_queue_control.sv
// Purpose: Egress queue configuration and queue-3 weighted scheduling
// Assumes: Frame and queue inputs come from logic on sys_clk
// Notes:   Decisions and grants appear one cycle after their request

`timescale 1ns/1ps
`default_nettype none

module pegq_port_egress_queue_control
  import pegq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       frameValid,
  input  wire logic       frameTagged,
  input  wire logic [1:0] framePrio,
  input  wire logic       frameToLowest,
  output logic            frameDone,
  output logic            frameDrop,
  output logic      [1:0] frameQueue,
  output logic            insertPvid,
  input  wire logic [3:0] queueNotEmpty,
  input  wire logic       txReady,
  output logic            grantValid,
  output logic      [1:0] grantQueue
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                   twoQ;
    logic                   glbIns;
    logic                   insLow;
    logic                   split;
    logic                   dropEn;
    logic                   ratioEn;
    logic [6:0]             ratio;
    logic [7:0]             rdData;
    logic                   frameDone;
    logic                   frameDrop;
    logic [1:0]             frameQueue;
    logic                   insertPvid;
    logic                   grantValid;
    logic [1:0]             grantQueue;
    logic [PEGQ_TICK_W-1:0] tick;
    logic                   intervalStart;
  } pegq_state_t;

  localparam logic [PEGQ_TICK_W-1:0] TICK_LAST = PEGQ_TICK_W'(PEGQ_INTERVAL_CYC - 1);

  pegq_state_t st_r;
  pegq_state_t st_nxt;

  pegq_qmode_t qMode;
  logic        weighted;
  logic        q3Allowed;
  logic        consume;
  logic [6:0]  creditLeft;

  // ****************************************************************
  // Queue-3 allowance
  // ****************************************************************
  // Allowance only matters in four-queue weighted mode; other modes keep strict order
  assign qMode     = pegq_qmode_t'({st_r.split, st_r.twoQ});
  assign weighted  = (qMode == PEGQ_Q4) && st_r.ratioEn;
  assign q3Allowed = queueNotEmpty[3] && !(weighted && creditLeft == 7'h00);
  assign consume   = st_nxt.grantValid && st_nxt.grantQueue == 2'h3 && weighted;

  pegq_sched_credit u_credit (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .reload     (st_r.intervalStart),
    .consume    (consume),
    .limit      (st_r.ratio),
    .creditLeft (creditLeft)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt            = st_r;
    st_nxt.frameDone  = 1'h0;
    st_nxt.grantValid = 1'h0;
    st_nxt.rdData     = 8'h00;

    // Register writes; reserved bits are simply not stored
    if (regWr) begin
      case (regAddr)
        PEGQ_ADDR_TWOQ:  st_nxt.twoQ   = regWrData[PEGQ_TWOQ_BIT];
        PEGQ_ADDR_GLB:   st_nxt.glbIns = regWrData[PEGQ_GLB_INS_BIT];
        PEGQ_ADDR_INS:   st_nxt.insLow = regWrData[PEGQ_INS_LOW_BIT];
        PEGQ_ADDR_SPLIT: begin
          st_nxt.split  = regWrData[PEGQ_SPLIT_BIT];
          st_nxt.dropEn = regWrData[PEGQ_DROP_BIT];
        end
        PEGQ_ADDR_RATIO: begin
          st_nxt.ratioEn = regWrData[PEGQ_RATIO_EN_BIT];
          st_nxt.ratio   = regWrData[6:0];
        end
        default: ;
      endcase
    end

    // Register reads; unmapped addresses return zero
    if (regRd) begin
      case (regAddr)
        PEGQ_ADDR_TWOQ:   st_nxt.rdData[PEGQ_TWOQ_BIT]    = st_r.twoQ;
        PEGQ_ADDR_GLB:    st_nxt.rdData[PEGQ_GLB_INS_BIT] = st_r.glbIns;
        PEGQ_ADDR_INS:    st_nxt.rdData[PEGQ_INS_LOW_BIT] = st_r.insLow;
        PEGQ_ADDR_SPLIT: begin
          st_nxt.rdData[PEGQ_SPLIT_BIT] = st_r.split;
          st_nxt.rdData[PEGQ_DROP_BIT]  = st_r.dropEn;
        end
        PEGQ_ADDR_RATIO:  st_nxt.rdData = {st_r.ratioEn, st_r.ratio};
        PEGQ_ADDR_CREDIT: st_nxt.rdData = {1'h0, creditLeft};
        default: ;
      endcase
    end

    // Frame classification
    if (frameValid) begin
      st_nxt.frameDone  = 1'h1;
      st_nxt.frameDrop  = frameTagged && st_r.dropEn;
      st_nxt.insertPvid = !frameTagged && frameToLowest
                          && st_r.insLow && st_r.glbIns;
      case (qMode)
        PEGQ_Q4: st_nxt.frameQueue = framePrio;
        PEGQ_Q2: st_nxt.frameQueue = {framePrio[1], framePrio[1]};
        // Reserved code is never relied on; it falls back to one queue
        default: st_nxt.frameQueue = 2'h0;
      endcase
    end

    // Interval timer
    st_nxt.intervalStart = 1'h0;
    if (st_r.tick == TICK_LAST) begin
      st_nxt.tick          = '0;
      st_nxt.intervalStart = 1'h1;
    end else begin
      st_nxt.tick = st_r.tick + PEGQ_TICK_W'(1);
    end

    // Transmit selection, highest allowed queue first
    if (txReady) begin
      st_nxt.grantValid = 1'h1;
      if (q3Allowed) begin
        st_nxt.grantQueue = 2'h3;
      end else if (queueNotEmpty[2]) begin
        st_nxt.grantQueue = 2'h2;
      end else if (queueNotEmpty[1]) begin
        st_nxt.grantQueue = 2'h1;
      end else if (queueNotEmpty[0]) begin
        st_nxt.grantQueue = 2'h0;
      end else begin
        st_nxt.grantValid = 1'h0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r               <= '0;
      st_r.twoQ          <= PEGQ_TWOQ_RST;
      st_r.glbIns        <= PEGQ_GLB_INS_RST;
      st_r.insLow        <= PEGQ_INS_LOW_RST;
      st_r.split         <= PEGQ_SPLIT_RST;
      st_r.dropEn        <= PEGQ_DROP_RST;
      st_r.ratioEn       <= PEGQ_RATIO_EN_RST;
      st_r.ratio         <= PEGQ_RATIO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData  = st_r.rdData;
  assign frameDone  = st_r.frameDone;
  assign frameDrop  = st_r.frameDrop;
  assign frameQueue = st_r.frameQueue;
  assign insertPvid = st_r.insertPvid;
  assign grantValid = st_r.grantValid;
  assign grantQueue = st_r.grantQueue;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence frame_in_s;
    frameValid ##0 1'b1;
  endsequence

  split_rsv_zero_a: assert property (regRd && regAddr == PEGQ_ADDR_SPLIT
    |=> regRdData[7:2] == 6'h00)
    else $error("Reserved split bits not zero");

  tag_drop_a: assert property (frame_in_s ##0 (frameTagged && st_r.dropEn)
    |=> frameDone && frameDrop)
    else $error("Tagged frame not dropped");

  tag_keep_a: assert property (frame_in_s ##0 !(frameTagged && st_r.dropEn)
    |=> !frameDrop)
    else $error("Frame dropped without cause");

  four_queue_a: assert property (frame_in_s ##0 qMode == PEGQ_Q4
    |=> frameQueue == $past(framePrio))
    else $error("Four-queue mapping wrong");

  two_queue_a: assert property (frame_in_s ##0 qMode == PEGQ_Q2
    |=> frameQueue == {2{$past(framePrio[1])}})
    else $error("Two-queue mapping wrong");

  one_queue_a: assert property (frame_in_s ##0 qMode == PEGQ_Q1
    |=> frameQueue == 2'h0)
    else $error("Single queue not used");

  pvid_gate_a: assert property (frame_in_s ##0 !st_r.glbIns
    |=> !insertPvid)
    else $error("Insertion without global enable");

  pvid_ins_a: assert property (frame_in_s ##0 (!frameTagged && frameToLowest
    && st_r.insLow && st_r.glbIns) |=> insertPvid)
    else $error("Source VLAN ID not inserted");

  strict_q3_a: assert property (txReady && queueNotEmpty[3] && !weighted
    |=> grantValid && grantQueue == 2'h3)
    else $error("Queue 3 not served first");

  ratio_cap_a: assert property (txReady && weighted && creditLeft == 7'h00
    |=> !(grantValid && grantQueue == 2'h3))
    else $error("Queue 3 exceeded its allowance");

  ratio_reset_a: assert property ($past(rst)
    |-> st_r.ratio == PEGQ_RATIO_RST && st_r.ratioEn == PEGQ_RATIO_EN_RST)
    else $error("Ratio reset value wrong");

  interval_len_a: assert property (st_r.intervalStart
    |=> !st_r.intervalStart [*8])
    else $error("Interval restarted too soon");

endmodule : pegq_port_egress_queue_control

`default_nettype wire

// file: hdl/pegq_sched_credit.sv
// Purpose: Packet allowance counter for one weighted transmit queue
// Assumes: Same clock as the caller; inputs already synchronous
// Notes:   Reload wins over a consume in the same cycle

`timescale 1ns/1ps
`default_nettype none

module pegq_sched_credit
  import pegq_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reload,
  input  wire logic       consume,
  input  wire logic [6:0] limit,
  output logic      [6:0] creditLeft
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [6:0] cnt;
  } pegq_credit_t;

  pegq_credit_t st_r;
  pegq_credit_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (reload) begin
      st_nxt.cnt = limit;
    end else if (consume && st_r.cnt != 7'h00) begin
      st_nxt.cnt = st_r.cnt - 7'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.cnt <= PEGQ_RATIO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign creditLeft = st_r.cnt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  credit_reload_a: assert property (@(posedge sys_clk) disable iff (rst)
    reload |=> creditLeft == $past(limit))
    else $error("Allowance not reloaded at interval start");

  credit_floor_a: assert property (@(posedge sys_clk) disable iff (rst)
    !reload && creditLeft == 7'h00 |=> creditLeft == 7'h00)
    else $error("Allowance wrapped below zero");

endmodule : pegq_sched_credit

`default_nettype wire

// file: pkg/pegq_pkg.sv
// Purpose: Shared constants for the port egress queue control block
// Assumes: One switch port, 8-bit register port, 50 MHz sys_clk
// Notes:   Offsets are byte addresses on the plain register port

`default_nettype none

package pegq_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] PEGQ_ADDR_TWOQ   = 8'h10;
  localparam logic [7:0] PEGQ_ADDR_GLB    = 8'h87;
  localparam logic [7:0] PEGQ_ADDR_INS    = 8'hB0;
  localparam logic [7:0] PEGQ_ADDR_SPLIT  = 8'hB1;
  localparam logic [7:0] PEGQ_ADDR_RATIO  = 8'hB2;
  localparam logic [7:0] PEGQ_ADDR_CREDIT = 8'hBE;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PEGQ_TWOQ_BIT     = 0;
  localparam int PEGQ_GLB_INS_BIT  = 2;
  localparam int PEGQ_INS_LOW_BIT  = 0;
  localparam int PEGQ_SPLIT_BIT    = 1;
  localparam int PEGQ_DROP_BIT     = 0;
  localparam int PEGQ_RATIO_EN_BIT = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       PEGQ_TWOQ_RST     = 1'h0;
  localparam logic       PEGQ_GLB_INS_RST  = 1'h0;
  localparam logic       PEGQ_INS_LOW_RST  = 1'h0;
  localparam logic       PEGQ_SPLIT_RST    = 1'h0;
  localparam logic       PEGQ_DROP_RST     = 1'h0;
  localparam logic       PEGQ_RATIO_EN_RST = 1'h1;
  localparam logic [6:0] PEGQ_RATIO_RST    = 7'h08;

  // ****************************************************************
  // Queue modes, {split, twoQ}
  // ****************************************************************
  typedef enum logic [1:0] {
    PEGQ_Q1   = 2'h0,
    PEGQ_Q2   = 2'h1,
    PEGQ_Q4   = 2'h2,
    PEGQ_QRSV = 2'h3
  } pegq_qmode_t;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int PEGQ_CLK_NS       = 20;
  localparam int PEGQ_INTERVAL_NS  = 20480;
  localparam int PEGQ_INTERVAL_CYC = (PEGQ_INTERVAL_NS / PEGQ_CLK_NS < 1) ? 1 :
                                     PEGQ_INTERVAL_NS / PEGQ_CLK_NS;
  localparam int PEGQ_TICK_W       = $clog2(PEGQ_INTERVAL_CYC + 1);

endpackage : pegq_pkg

`default_nettype wire

// file: test/tb_port_egress_queue_control.sv
// Purpose: Self-checking bench for the port egress queue control block
// Assumes: Register port strobes of one cycle, read data one cycle later
// Notes:   Random frames from a fixed seed; scheduler corners written by hand

`timescale 1ns/1ps
`default_nettype none

module tb_port_egress_queue_control
  import pegq_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       sysClk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic       frameValid = 1'b0, frameTagged = 1'b0, frameToLowest = 1'b0, txReady = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rdv;
  logic [1:0] framePrio = 2'h0, frameQueue, grantQueue;
  logic [3:0] queueNotEmpty = 4'h0, mask;
  logic       frameDone, frameDrop, insertPvid, grantValid, dropEn;
  logic [31:0] rnd;
  integer     seed = 32'h2b86_5e75;
  int         failCount = 0, numChecks = 0, m, i, k, n;

  always #10 sysClk = ~sysClk;

  pegq_port_egress_queue_control dut (
    .sys_clk(sysClk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .frameValid(frameValid),
    .frameTagged(frameTagged), .framePrio(framePrio), .frameToLowest(frameToLowest),
    .frameDone(frameDone), .frameDrop(frameDrop), .frameQueue(frameQueue),
    .insertPvid(insertPvid), .queueNotEmpty(queueNotEmpty), .txReady(txReady),
    .grantValid(grantValid), .grantQueue(grantQueue)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // Reserved mode is treated as a single queue
  function automatic logic [1:0] qexp(input logic [1:0] md, input logic [1:0] p);
    if (md == 2'h2) return p;
    if (md == 2'h1) return {p[1], p[1]};
    return 2'h0;
  endfunction : qexp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge sysClk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sysClk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk("register", d, exp);
  endtask : rdChk

  task automatic frm(input logic tg, input logic [1:0] p, input logic low,
                     input logic [1:0] md, input logic exIns);
    @(posedge sysClk);
    frameValid <= 1'b1; frameTagged <= tg; framePrio <= p; frameToLowest <= low;
    @(posedge sysClk);
    frameValid <= 1'b0;
    #1;
    chk("frameDone", {7'h0, frameDone}, 8'h01);
    chk("frameDrop", {7'h0, frameDrop}, {7'h0, tg & dropEn});
    chk("frameQueue", {6'h0, frameQueue}, {6'h0, qexp(md, p)});
    chk("insertPvid", {7'h0, insertPvid}, {7'h0, exIns});
  endtask : frm

  task automatic grant(input logic [3:0] qm, input logic ev, input logic [1:0] eq);
    @(posedge sysClk);
    txReady <= 1'b1; queueNotEmpty <= qm;
    @(posedge sysClk);
    txReady <= 1'b0;
    #1;
    chk("grantValid", {7'h0, grantValid}, {7'h0, ev});
    if (ev) chk("grantQueue", {6'h0, grantQueue}, {6'h0, eq});
  endtask : grant

  // Bounded poll: the reload may be up to one interval away
  task automatic waitAllow(input logic [7:0] v);
    n = 0;
    do begin
      rd(PEGQ_ADDR_CREDIT, rdv);
      n++;
    end while (rdv !== v && n < 1200);
    chk("allowance", rdv, v);
    if (rdv !== v) summarize();
  endtask : waitAllow

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge sysClk);
    rst <= 1'b0;
    @(posedge sysClk);
    rdChk(PEGQ_ADDR_SPLIT, 8'h00);
    rdChk(PEGQ_ADDR_RATIO, 8'h88);
    rdChk(PEGQ_ADDR_INS, 8'h00);
    rdChk(PEGQ_ADDR_TWOQ, 8'h00);
    rdChk(PEGQ_ADDR_GLB, 8'h00);
    wr(PEGQ_ADDR_CREDIT, 8'h55);
    rdChk(PEGQ_ADDR_CREDIT, 8'h08);
    rdChk(8'h55, 8'h00);
    wr(PEGQ_ADDR_SPLIT, 8'hFF);
    rdChk(PEGQ_ADDR_SPLIT, 8'h03);
    wr(PEGQ_ADDR_RATIO, 8'h5A);
    rdChk(PEGQ_ADDR_RATIO, 8'h5A);
    // Every queue mode, random drop enable and frames
    for (m = 0; m < 4; m++) begin
      rnd = $random(seed);
      dropEn = rnd[0];
      wr(PEGQ_ADDR_SPLIT, {6'h0, m[1], dropEn});
      wr(PEGQ_ADDR_TWOQ, {7'h0, m[0]});
      for (i = 0; i < 16; i++) begin
        rnd = $random(seed);
        frm(rnd[0], rnd[2:1], rnd[3], m[1:0], 1'b0);
      end
    end
    // Insertion needs both the port option and the global enable
    dropEn = 1'b0;
    wr(PEGQ_ADDR_SPLIT, 8'h00);
    wr(PEGQ_ADDR_TWOQ, 8'h00);
    for (k = 0; k < 16; k++) begin
      wr(PEGQ_ADDR_GLB, {5'h0, k[0], 2'h0});
      wr(PEGQ_ADDR_INS, {7'h0, k[1]});
      frm(k[2], 2'h3, k[3], 2'h0, !k[2] & k[3] & k[1] & k[0]);
    end
    // Weighted queue 3 in four-queue mode
    wr(PEGQ_ADDR_SPLIT, 8'h02);
    wr(PEGQ_ADDR_RATIO, 8'h83);
    waitAllow(8'h03);
    repeat (3) grant(4'h8, 1'b1, 2'h3);
    grant(4'h8, 1'b0, 2'h0);
    rdChk(PEGQ_ADDR_CREDIT, 8'h00);
    grant(4'hC, 1'b1, 2'h2);
    waitAllow(8'h03);
    grant(4'h8, 1'b1, 2'h3);
    // Strict priority once the ratio is disabled
    wr(PEGQ_ADDR_RATIO, 8'h03);
    repeat (6) grant(4'hF, 1'b1, 2'h3);
    for (i = 0; i < 12; i++) begin
      rnd = $random(seed);
      mask = rnd[3:0];
      grant(mask, mask != 4'h0,
            mask[3] ? 2'h3 : mask[2] ? 2'h2 : mask[1] ? 2'h1 : 2'h0);
    end
    summarize();
  end

  // Hang guard
  initial begin
    #2_000_000;
    failCount++;
    $display("ERROR watchdog expected finish seen hang");
    summarize();
  end

endmodule : tb_port_egress_queue_control

`default_nettype wire
